// file: common/seerd_pkg.sv
// shared constants and types of the serial memory read/poll client
package seerd_pkg;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int WRITE_CYCLE_NS = 5000000;
	// shortest-time rounding: whole cycles, floor
	localparam int WRITE_CYCLES   = WRITE_CYCLE_NS / CLK_PERIOD_NS;
	localparam int ADDR_W         = 17;
	localparam int DATA_W         = 8;
	localparam int FIFO_DEPTH     = 8;
	localparam int FIFO_W         = ADDR_W + DATA_W;
	localparam int PAGE_BITS      = 7;
	// control byte field positions
	localparam int CTRL_CODE_LSB  = 4;
	localparam int CTRL_BLOCK_BIT = 3;
	localparam int CTRL_CS_HI_BIT = 2;
	localparam int CTRL_CS_LO_BIT = 1;
	localparam int CTRL_RW_BIT    = 0;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [16:0] PTR_RST       = 17'h00000;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

	typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_HACK} seerd_state_e;
	typedef enum logic [1:0] {PH_CTRL, PH_AHI, PH_ALO, PH_WDAT} seerd_phase_e;
endpackage : seerd_pkg

// file: verilog/seerd_fifo.sv
// write-data fifo between the serial client and the memory array
module seerd_fifo #(
	parameter int WIDTH = seerd_pkg::FIFO_W,
	parameter int DEPTH = seerd_pkg::FIFO_DEPTH
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} seerd_fifo_s;

	seerd_fifo_s s_r;
	seerd_fifo_s s_nxt;
	logic        do_push;
	logic        do_pop;

	assign in_ready_out  = (s_r.cnt != (AW+1)'(DEPTH));
	assign out_valid_out = (s_r.cnt != '0);
	assign out_data_out  = s_r.mem[s_r.rp];

	always_comb begin
		s_nxt   = s_r;
		do_push = in_valid_in && in_ready_out;
		do_pop  = out_valid_out && out_ready_in;
		if (do_push) begin
			s_nxt.mem[s_r.wp] = in_data_in;
			s_nxt.wp          = s_r.wp + 1'b1;
		end
		if (do_pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // seerd_fifo

// file: verilog/seerd_client.sv
// serial memory client: ack polling, current/random/sequential reads, write capture
module seerd_client #(
	parameter logic [3:0] DEV_TYPE_CODE = 4'h5, // arbitrary value
	parameter int         WRITE_CYCLES  = seerd_pkg::WRITE_CYCLES
) (
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	input  wire logic                          scl_in,
	input  wire logic                          sda_in,
	output logic                               sda_out,
	output logic                               sda_oe_out,
	input  wire logic                          chip_select_high_pin_in,
	input  wire logic                          chip_select_low_pin_in,
	output logic                               rd_en_out,
	output logic [seerd_pkg::ADDR_W-1:0]       rd_addr_out,
	input  wire logic [seerd_pkg::DATA_W-1:0]  rd_data_in,
	output logic                               wr_valid_out,
	output logic [seerd_pkg::ADDR_W-1:0]       wr_addr_out,
	output logic [seerd_pkg::DATA_W-1:0]       wr_data_out,
	input  wire logic                          wr_ready_in,
	output logic                               write_busy_out
);
	localparam int CW = $clog2(WRITE_CYCLES + 1);
	if (WRITE_CYCLES < 1) begin : g_bad_wc
		$error("write cycle count must be at least one");
	end
	typedef struct packed {
		logic [1:0]              scl_sy;
		logic [1:0]              sda_sy;
		logic [1:0]              csh_sy;
		logic [1:0]              csl_sy;
		logic                    scl_q;
		logic                    sda_q;
		seerd_pkg::seerd_state_e st;
		seerd_pkg::seerd_phase_e ph;
		logic                    nxt_send;
		logic [3:0]              bitcnt;
		logic [7:0]              sh;
		logic [7:0]              ctrl;
		logic [7:0]              launch;
		logic [7:0]              ahi;
		logic [7:0]              tx;
		logic [16:0]             ptr;
		logic                    oe;
		logic                    wr_pend;
		logic                    busy;
		logic [CW-1:0]           wc_cnt;
		logic                    rd_en;
		logic                    rd_cap;
		logic                    push;
		logic [24:0]             push_data;
	} seerd_regs_s;
	seerd_regs_s s_r;
	seerd_regs_s s_nxt;
	logic        scl_s;
	logic        sda_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_ev;
	logic        stop_ev;
	logic        fifo_ready;
	logic        ctrl_done;
	logic        addr_ok;
	logic        blocked;
	logic        byte_sent;
	logic        host_ack;
	logic        host_nack;
	// only the second sync stage and its history feed any logic
	assign scl_s    = s_r.scl_sy[1];
	assign sda_s    = s_r.sda_sy[1];
	assign scl_rise = scl_s && !s_r.scl_q;
	assign scl_fall = !scl_s && s_r.scl_q;
	assign start_ev = scl_s && s_r.scl_q && s_r.sda_q && !sda_s;
	assign stop_ev  = scl_s && s_r.scl_q && !s_r.sda_q && sda_s;
	// open drain: only ever pulls low
	assign sda_out        = 1'b0;
	assign sda_oe_out     = s_r.oe;
	assign rd_en_out      = s_r.rd_en;
	assign rd_addr_out    = s_r.ptr;
	assign write_busy_out = s_r.busy;
	always_comb begin
		s_nxt           = s_r;
		s_nxt.scl_sy    = {s_r.scl_sy[0], scl_in};
		s_nxt.sda_sy    = {s_r.sda_sy[0], sda_in};
		s_nxt.csh_sy    = {s_r.csh_sy[0], chip_select_high_pin_in};
		s_nxt.csl_sy    = {s_r.csl_sy[0], chip_select_low_pin_in};
		s_nxt.scl_q     = scl_s;
		s_nxt.sda_q     = sda_s;
		s_nxt.rd_en     = 1'b0;
		s_nxt.push      = 1'b0;
		s_nxt.rd_cap    = s_r.rd_en;
		ctrl_done       = 1'b0;
		byte_sent       = 1'b0;
		host_ack        = 1'b0;
		host_nack       = 1'b0;
		// type code and chip selects against straps
		addr_ok = (s_r.sh[7:seerd_pkg::CTRL_CODE_LSB] == DEV_TYPE_CODE)
			&& (s_r.sh[seerd_pkg::CTRL_CS_HI_BIT] == s_r.csh_sy[1])
			&& (s_r.sh[seerd_pkg::CTRL_CS_LO_BIT] == s_r.csl_sy[1]);
		// silent to the launching control byte
		blocked = s_r.busy && (s_r.sh[7:1] == s_r.launch[7:1]);
		// memory answers one cycle after the request
		if (s_r.rd_cap) begin
			s_nxt.tx = rd_data_in;
		end
		if (s_r.busy) begin
			s_nxt.wc_cnt = s_r.wc_cnt - 1'b1;
			if (s_r.wc_cnt == CW'(1)) begin
				s_nxt.busy = 1'b0;
			end
		end
		if (start_ev) begin
			// repeated start keeps a pending write; the pointer stays loaded
			s_nxt.st     = seerd_pkg::ST_RECV;
			s_nxt.ph     = seerd_pkg::PH_CTRL;
			s_nxt.bitcnt = 4'h0;
			s_nxt.oe     = 1'b0;
		end else if (stop_ev) begin
			// stop ends any transfer and frees the line
			s_nxt.st = seerd_pkg::ST_IDLE;
			s_nxt.oe = 1'b0;
			if (s_r.wr_pend) begin
				s_nxt.busy    = 1'b1;
				s_nxt.wc_cnt  = CW'(WRITE_CYCLES);
				s_nxt.wr_pend = 1'b0;
			end
		end else begin
			unique case (s_r.st)
				seerd_pkg::ST_IDLE: begin
				end
				seerd_pkg::ST_RECV: begin
					if (scl_rise && s_r.bitcnt != seerd_pkg::BITS_PER_BYTE) begin
						s_nxt.sh     = {s_r.sh[6:0], sda_s};
						s_nxt.bitcnt = s_r.bitcnt + 4'h1;
					end else if (scl_fall && s_r.bitcnt == seerd_pkg::BITS_PER_BYTE) begin
						s_nxt.st       = seerd_pkg::ST_ACK;
						s_nxt.oe       = 1'b1;
						s_nxt.nxt_send = 1'b0;
						unique case (s_r.ph)
							seerd_pkg::PH_CTRL: begin
								ctrl_done = 1'b1;
								s_nxt.ctrl = s_r.sh;
								if (!addr_ok || blocked) begin
									s_nxt.st = seerd_pkg::ST_IDLE;
									s_nxt.oe = 1'b0;
								end else if (s_r.sh[seerd_pkg::CTRL_RW_BIT]) begin
									s_nxt.nxt_send = 1'b1;
									s_nxt.rd_en    = 1'b1;
								end else begin
									s_nxt.ph = seerd_pkg::PH_AHI;
								end
							end
							seerd_pkg::PH_AHI: begin
								s_nxt.ahi = s_r.sh;
								s_nxt.ph  = seerd_pkg::PH_ALO;
							end
							seerd_pkg::PH_ALO: begin
								// high part first, then low byte
								s_nxt.ptr = {s_r.ctrl[seerd_pkg::CTRL_BLOCK_BIT], s_r.ahi, s_r.sh};
								s_nxt.ph  = seerd_pkg::PH_WDAT;
							end
							seerd_pkg::PH_WDAT: begin
								// a full fifo refuses the byte with no acknowledge
								if (fifo_ready) begin
									s_nxt.push      = 1'b1;
									s_nxt.push_data = {s_r.ptr, s_r.sh};
									s_nxt.ptr[seerd_pkg::PAGE_BITS-1:0] =
										s_r.ptr[seerd_pkg::PAGE_BITS-1:0] + 7'h01;
									s_nxt.wr_pend   = 1'b1;
									s_nxt.launch    = s_r.ctrl;
								end else begin
									s_nxt.st = seerd_pkg::ST_IDLE;
									s_nxt.oe = 1'b0;
								end
							end
						endcase
					end
				end
				seerd_pkg::ST_ACK: begin
					if (scl_fall) begin
						s_nxt.bitcnt = 4'h0;
						if (s_r.nxt_send) begin
							s_nxt.st = seerd_pkg::ST_SEND;
							s_nxt.oe = !s_r.tx[7];
						end else begin
							s_nxt.st = seerd_pkg::ST_RECV;
							s_nxt.oe = 1'b0;
						end
					end
				end
				seerd_pkg::ST_SEND: begin
					if (scl_fall) begin
						if (s_r.bitcnt == 4'h7) begin
							// step within the half; wrap; follow
							byte_sent = 1'b1;
							s_nxt.oe  = 1'b0;
							s_nxt.st  = seerd_pkg::ST_HACK;
							s_nxt.ptr = {s_r.ptr[16], s_r.ptr[15:0] + 16'h0001};
						end else begin
							s_nxt.bitcnt = s_r.bitcnt + 4'h1;
							s_nxt.tx     = {s_r.tx[6:0], 1'b0};
							s_nxt.oe     = !s_r.tx[6];
						end
					end
				end
				seerd_pkg::ST_HACK: begin
					if (scl_rise) begin
						if (!sda_s) begin
							// host ack asks for the next byte
							host_ack       = 1'b1;
							s_nxt.rd_en    = 1'b1;
							s_nxt.nxt_send = 1'b1;
							s_nxt.st       = seerd_pkg::ST_ACK;
						end else begin
							// no ack, keep the line released
							host_nack = 1'b1;
							s_nxt.st  = seerd_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r        <= '0;
			s_r.scl_sy <= 2'h3;
			s_r.sda_sy <= 2'h3;
			s_r.scl_q  <= 1'b1;
			s_r.sda_q  <= 1'b1;
			s_r.ptr    <= seerd_pkg::PTR_RST;
			s_r.tx     <= seerd_pkg::BYTE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end
	seerd_fifo #(
		.WIDTH(seerd_pkg::FIFO_W),
		.DEPTH(seerd_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (s_r.push),
		.in_data_in    (s_r.push_data),
		.in_ready_out  (fifo_ready),
		.out_valid_out (wr_valid_out),
		.out_data_out  ({wr_addr_out, wr_data_out}),
		.out_ready_in  (wr_ready_in)
	);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	AST_BUSY_NACK: assert property (ctrl_done && blocked |=> !sda_oe_out && s_r.st == seerd_pkg::ST_IDLE)
		else $error("busy client acknowledged its launching control byte");
	AST_IDLE_ACK: assert property (ctrl_done && addr_ok && !blocked |=> sda_oe_out ##0 s_r.st == seerd_pkg::ST_ACK)
		else $error("matching control byte not acknowledged");
	AST_READ_FETCH: assert property (ctrl_done && addr_ok && !blocked && s_r.sh[0] |=> rd_en_out ##1 !rd_en_out)
		else $error("read control byte did not fetch one byte");
	AST_PTR_STEP: assert property (byte_sent && s_r.ptr[15:0] != 16'hffff |=> rd_addr_out == $past(rd_addr_out) + 17'h00001)
		else $error("pointer did not step by one");
	AST_WRAP_LOW: assert property (byte_sent && s_r.ptr == 17'h0ffff |=> rd_addr_out == 17'h00000)
		else $error("lower half did not wrap");
	AST_WRAP_HIGH: assert property (byte_sent && s_r.ptr == 17'h1ffff |=> rd_addr_out == 17'h10000)
		else $error("upper half did not wrap");
	AST_NACK_RELEASE: assert property (host_nack |=> !sda_oe_out [*3])
		else $error("line not released after missing ack");
	AST_STOP_RELEASE: assert property (stop_ev |=> !sda_oe_out)
		else $error("line driven after stop");
	AST_SEQ_NEXT: assert property (host_ack |=> rd_en_out ##1 s_r.rd_cap)
		else $error("host ack did not fetch the next byte");
	AST_WRITE_BUSY: assert property (stop_ev && s_r.wr_pend |=> write_busy_out ##1 write_busy_out)
		else $error("write cycle did not start at stop");
	AST_ADDR_LOAD: assert property (s_r.st == seerd_pkg::ST_RECV && s_r.ph == seerd_pkg::PH_ALO && scl_fall
		&& s_r.bitcnt == 4'h8 && !start_ev && !stop_ev |=> rd_addr_out[15:0] == {$past(s_r.ahi), $past(s_r.sh)})
		else $error("address bytes not loaded into pointer");
	COV_POLL_NACK: cover property (ctrl_done && blocked);
	COV_SEQ_READ: cover property (host_ack);
	COV_WRAP: cover property (byte_sent && s_r.ptr[15:0] == 16'hffff);
	COV_WRITE: cover property (s_r.push);
endmodule // seerd_client

// file: tb/seerd_host_model.sv
// bus host model: drives the bus clock and releases or pulls the data line
module seerd_host_model (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// half bus period of eight clocks leaves the client's sync margin
	task automatic w();
		repeat (8) @(negedge clk_in);
	endtask
	task automatic start_cond();
		@(negedge clk_in);
		sda_out = 1'b1;
		w();
		scl_out = 1'b1;
		w();
		sda_out = 1'b0;
		w();
		scl_out = 1'b0;
	endtask
	// stop ends a frame, clock then stands high
	task automatic stop_cond();
		@(negedge clk_in);
		sda_out = 1'b0;
		w();
		scl_out = 1'b1;
		w();
		sda_out = 1'b1;
		w();
	endtask
	// data only changes while the clock is low
	task automatic bit_slot(input logic v, output logic seen);
		@(negedge clk_in);
		sda_out = v;
		w();
		scl_out = 1'b1;
		w();
		seen = sda_in;
		scl_out = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
		bit_slot(1'b1, s);
		ack = !s;
	endtask
	// low ack asks for more, high ack ends the read
	task automatic recv_byte(input logic ack_it, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, s);
			b[i] = s;
		end
		bit_slot(!ack_it, s);
	endtask
endmodule // seerd_host_model

// file: tb/tb_serial_eeprom_read_and_poll.sv
// self-checking bench of the serial memory read and poll client
module tb_serial_eeprom_read_and_poll;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] TYPE_CODE = 4'h5; // arbitrary value
	localparam logic       CS_HI     = 1'b1;
	localparam logic       CS_LO     = 1'b0;
	localparam int         WCYC      = 400;
	logic        clk_in, rst_in, scl, sda_host, sda_w, wr_ready;
	logic        sda_out, sda_oe, rd_en, wr_valid, busy;
	logic [16:0] rd_addr, wr_addr;
	logic [7:0]  rd_data, wr_data;
	int          bad_count, tests_run, cyc;
	// open-drain wire with pull-up
	assign sda_w = sda_host & ~(sda_oe & ~sda_out);
	seerd_client #(.DEV_TYPE_CODE(TYPE_CODE), .WRITE_CYCLES(WCYC)) DUT (
		.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_out(sda_oe),
		.chip_select_high_pin_in(CS_HI), .chip_select_low_pin_in(CS_LO),
		.rd_en_out(rd_en), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
		.wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
		.wr_ready_in(wr_ready), .write_busy_out(busy));
	seerd_host_model host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_host));
	function automatic logic [7:0] mem_byte(input logic [16:0] a);
		return a[7:0] ^ {a[16], a[14:8]};
	endfunction
	function automatic logic [7:0] ctrl(input logic blk, input logic rw);
		return {TYPE_CODE, blk, CS_HI, CS_LO, rw};
	endfunction
	// array answers the cycle after a read request
	always @(posedge clk_in) if (rd_en) rd_data <= mem_byte(rd_addr);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic read_bytes(input logic [16:0] a, input logic blk, input int n);
		logic       ack;
		logic [7:0] b;
		host.start_cond();
		host.send_byte(ctrl(blk, 1'b1), ack);
		check(32'(ack), 1);
		for (int i = 0; i < n; i++) begin
			host.recv_byte(i < n - 1, b);
			check(32'(b), 32'(mem_byte(a)));
			a = {a[16], a[15:0] + 16'h0001};
		end
		repeat (6) @(negedge clk_in);
		check(32'(sda_oe), 0);
		host.stop_cond();
		check(32'(sda_oe), 0);
	endtask
	task automatic rand_read(input logic [16:0] a, input int n);
		logic ack;
		host.start_cond();
		host.send_byte(ctrl(a[16], 1'b0), ack);
		check(32'(ack), 1);
		host.send_byte(a[15:8], ack);
		host.send_byte(a[7:0], ack);
		check(32'(ack), 1);
		read_bytes(a, a[16], n);
	endtask
	task automatic s_random_then_current();
		rand_read(17'h01234, 1);
		read_bytes(17'h01235, 1'b0, 1);
	endtask
	task automatic s_seq_lower_wrap();
		rand_read(17'h0fffe, 3);
		read_bytes(17'h00001, 1'b0, 1);
	endtask
	task automatic s_seq_upper_wrap();
		rand_read(17'h1ffff, 2);
		read_bytes(17'h10001, 1'b0, 1);
	endtask
	task automatic s_refuse();
		logic       ack;
		logic [7:0] bad [3];
		bad[0] = {TYPE_CODE, 1'b0, ~CS_HI, CS_LO, 1'b1};
		bad[1] = {TYPE_CODE, 1'b0, CS_HI, ~CS_LO, 1'b1};
		bad[2] = {TYPE_CODE ^ 4'h3, 1'b0, CS_HI, CS_LO, 1'b1};
		for (int i = 0; i < 3; i++) begin
			host.start_cond();
			host.send_byte(bad[i], ack);
			check(32'(ack), 0);
			host.stop_cond();
		end
	endtask
	task automatic s_fill_poll();
		logic        ack;
		int          nacks;
		logic [16:0] a;
		a = 17'h0207c;
		nacks = 0;
		host.start_cond();
		host.send_byte(ctrl(a[16], 1'b0), ack);
		host.send_byte(a[15:8], ack);
		host.send_byte(a[7:0], ack);
		// buffer of eight refuses the ninth byte while the consumer stalls
		for (int i = 0; i < 9; i++) begin
			host.send_byte(8'ha0 + 8'(i), ack);
			check(32'(ack), 32'(i < 8));
		end
		host.stop_cond();
		check(32'(busy), 1);
		host.start_cond();
		host.send_byte(ctrl(1'b1, 1'b0), ack);
		check(32'(ack), 1);
		// bounded poll, resending start and control byte on each refusal
		for (int i = 0; i < 10; i++) begin
			host.start_cond();
			host.send_byte(ctrl(a[16], 1'b0), ack);
			if (ack) break;
			nacks++;
		end
		check(32'(nacks > 0), 1);
		check(32'({ack, busy}), 32'h2);
		host.stop_cond();
		for (int i = 0; i < 8; i++) begin
			check(32'(wr_valid), 1);
			check(32'(wr_addr), 32'({a[16:7], a[6:0] + 7'(i)}));
			check(32'(wr_data), 32'(8'ha0 + 8'(i)));
			wr_ready = 1'b1;
			@(negedge clk_in);
			wr_ready = 1'b0;
			@(negedge clk_in);
		end
		check(32'(wr_valid), 0);
	endtask
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// a hang is cut short well past the expected run length
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk_in);
			cyc++;
			if (cyc == 60000) begin
				bad_count++;
				tally_and_finish();
			end
		end
	end
	initial begin
		rst_in = 1'b1;
		wr_ready = 1'b0;
		rd_data = 8'h00;
		bad_count = 0;
		tests_run = 0;
		repeat (10) @(negedge clk_in);
		check(32'({sda_oe, rd_en, wr_valid, busy}), 0);
		rst_in = 1'b0;
		repeat (8) @(negedge clk_in);
		s_random_then_current();
		s_seq_lower_wrap();
		s_seq_upper_wrap();
		s_refuse();
		s_fill_poll();
		tally_and_finish();
	end
endmodule // tb_serial_eeprom_read_and_poll
